// >>> src/acfg_config_bank.sv
// Serial configuration register bank of a two-channel converter
//
// Behaviour
// - A frame is sixteen serial clocks; one register access is decoded per frame.
// - The first three frame bits decide which register, if any, is written.
// - Write flag zero: rest of frame discarded, both registers kept.
// - Write one, select zero: next twelve bits load the control register.
// - Write one, select one: next six bits load the range register.
// - Bit 15 write flag, bit 14 zero, bit 13 register select.
// - Control fields: channel 10, config 9:8, power 7:6, coding 5, ref 4, seq 3:2.
// - Control settings apply to the conversion after the write.
// - Control register is all zero after power-up.
// - Channel bit picks next input, or last channel when sequencing.
// - Config bits with channel bit set single, differential or pseudo differential.
// - Coding zero gives twos complement, one gives straight binary.
// - Every sequenced result uses coding from the latest control write.
// - Reference bit zero selects external, one selects internal reference.
// - Every sequenced conversion uses reference from the latest control write.
// - Both registers are write-only with no readback path.
// - Power codes: 11 shutdown, 10 autoshutdown, 01 autostandby, 00 normal.
// - Sequencer 1,0 runs channel 0 up to final; 00 and 11 single channel.
// - Range fields reset to 00, widest bipolar range; others half, quarter, unipolar.
`timescale 1ns/10ps
`include "acfg_defines.svh"
module acfg_config_bank (
    // Core clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Serial link
    input wire logic serialClk,
    input wire logic chipSelN,
    input wire logic serialDataIn,
    // Conversion setup for the running conversion
    output logic convActive,
    output logic activeChannel,
    output logic posInputSel,
    output logic negToGround,
    output acfg_pkg::acfg_input_cfg_t inputConfig,
    output logic configInvalid,
    output logic [1:0] activeRange,
    output logic codingStraight,
    output logic refInternal,
    output logic seqRunning,
    // Power state
    output acfg_pkg::acfg_power_t powerMode,
    output logic poweredDown,
    output logic refPowered
);

    ////////////////////////////////////////////////////////////////////////
    // Link side and crossings

    acfg_frame_if frameBus ();

    logic toggleSync;
    logic toggleSeen_reg;
    logic selSyncN;
    logic selSeenN_reg;
    logic frameDone;
    logic convStart;
    logic csRise;

    acfg_frame_rx frameRx (
        .serialClk(serialClk),
        .rst(rst),
        .chipSelN(chipSelN),
        .serialDataIn(serialDataIn),
        .frame(frameBus.tx)
    );

    acfg_sync #(
        .WIDTH(1),
        .INIT(1'b0)
    ) toggleSyncer (
        .clk(ref_clk),
        .rst(rst),
        .asyncIn(frameBus.frameToggle),
        .syncOut(toggleSync)
    );

    acfg_sync #(
        .WIDTH(1),
        .INIT(1'b1)
    ) selectSyncer (
        .clk(ref_clk),
        .rst(rst),
        .asyncIn(chipSelN),
        .syncOut(selSyncN)
    );

    // Edge memory for both crossed signals
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            toggleSeen_reg <= 1'b0;
            selSeenN_reg <= 1'b1;
        end else begin
            toggleSeen_reg <= toggleSync;
            selSeenN_reg <= selSyncN;
        end
    end

    assign frameDone = toggleSync ^ toggleSeen_reg;
    assign convStart = selSeenN_reg && !selSyncN;
    // Select release, also ends a cut frame
    assign csRise = !selSeenN_reg && selSyncN;

    ////////////////////////////////////////////////////////////////////////
    // Frame decode

    logic [15:0] word;
    logic writeFlag;
    logic zeroFlag;
    logic regSelect;
    logic ctrlWrite;
    logic rangeWrite;

    // Word is stable for many core cycles after the toggle
    assign word = frameBus.frameWord;
    assign writeFlag = word[`ACFG_WRITE_POS];
    assign zeroFlag = word[`ACFG_ZERO_POS];
    assign regSelect = word[`ACFG_RSEL_POS];

    always_comb begin
        ctrlWrite = 1'b0;
        rangeWrite = 1'b0;
        if (!frameDone) begin
            ctrlWrite = 1'b0;
        end else if (!writeFlag) begin
            ctrlWrite = 1'b0;
        end else if (zeroFlag) begin
            ctrlWrite = 1'b0;
        end else if (!regSelect) begin
            ctrlWrite = 1'b1;
        end else begin
            rangeWrite = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write-only registers, no readback port exists

    logic [11:0] control_reg;
    logic [5:0] range_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            control_reg <= `ACFG_CTRL_RESET;
        end else if (ctrlWrite) begin
            control_reg <= word[`ACFG_CTRL_HI:`ACFG_CTRL_LO];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            range_reg <= `ACFG_RANGE_RESET;
        end else if (rangeWrite) begin
            range_reg <= word[`ACFG_RANGE_HI:`ACFG_RANGE_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control fields

    logic ctrlChannel;
    logic [1:0] ctrlCfg;
    logic [1:0] ctrlPower;
    logic ctrlCoding;
    logic ctrlRef;
    logic sequencer_ctrl_hi;
    logic sequencer_ctrl_lo;
    logic seqMode;
    logic [1:0] wordPower;
    logic wordSeq;

    assign ctrlChannel = control_reg[`ACFG_CHAN_POS-1];
    assign ctrlCfg = control_reg[`ACFG_CFG_HI-1:`ACFG_CFG_LO-1];
    assign ctrlPower = control_reg[`ACFG_PWR_HI-1:`ACFG_PWR_LO-1];
    assign ctrlCoding = control_reg[`ACFG_CODING_POS-1];
    assign ctrlRef = control_reg[`ACFG_REF_POS-1];
    assign sequencer_ctrl_hi = control_reg[`ACFG_SEQ_HI-1];
    assign sequencer_ctrl_lo = control_reg[`ACFG_SEQ_LO-1];
    assign seqMode = sequencer_ctrl_hi && !sequencer_ctrl_lo;

    // Fields of a control word still being committed
    assign wordPower = word[`ACFG_PWR_HI:`ACFG_PWR_LO];
    assign wordSeq = word[`ACFG_SEQ_HI] && !word[`ACFG_SEQ_LO];

    ////////////////////////////////////////////////////////////////////////
    // Sequencer pointer

    logic seqPtr_reg;
    logic nextChannel;

    always_comb begin
        if (seqMode) begin
            nextChannel = seqPtr_reg;
        end else begin
            nextChannel = ctrlChannel;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seqPtr_reg <= 1'b0;
        end else if (ctrlWrite && wordSeq) begin
            seqPtr_reg <= 1'b0;
        end else if (convStart && seqMode) begin
            if (seqPtr_reg == ctrlChannel) begin
                seqPtr_reg <= 1'b0;
            end else begin
                seqPtr_reg <= seqPtr_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion setup, latched at conversion start

    logic [1:0] nextRange;

    always_comb begin
        if (nextChannel) begin
            nextRange = range_reg[`ACFG_RANGE1_HI:`ACFG_RANGE1_LO];
        end else begin
            nextRange = range_reg[`ACFG_RANGE0_HI:`ACFG_RANGE0_LO];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            activeChannel <= 1'b0;
            activeRange <= 2'h0;
            codingStraight <= 1'b0;
            refInternal <= 1'b0;
            seqRunning <= 1'b0;
        end else if (convStart) begin
            activeChannel <= nextChannel;
            activeRange <= nextRange;
            codingStraight <= ctrlCoding;
            refInternal <= ctrlRef;
            seqRunning <= seqMode;
        end
    end

    // Input pin routing
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inputConfig <= acfg_pkg::ACFG_CFG_SINGLE;
            posInputSel <= 1'b0;
            negToGround <= 1'b1;
            configInvalid <= 1'b0;
        end else if (convStart) begin
            inputConfig <= acfg_pkg::acfg_input_cfg_t'(ctrlCfg);
            configInvalid <= 1'b0;
            case (ctrlCfg)
                2'h0: begin
                    posInputSel <= nextChannel;
                    negToGround <= 1'b1;
                end
                2'h1, 2'h2: begin
                    posInputSel <= 1'b0;
                    negToGround <= 1'b0;
                end
                default: begin
                    posInputSel <= 1'b0;
                    negToGround <= 1'b1;
                    configInvalid <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power and conversion state

    acfg_pkg::acfg_state_t state_reg;
    logic autoPower;

    assign autoPower = (ctrlPower == 2'h1) || (ctrlPower == 2'h2);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= acfg_pkg::ACFG_ST_READY;
        end else begin
            case (state_reg)
                acfg_pkg::ACFG_ST_READY, acfg_pkg::ACFG_ST_ASLEEP: begin
                    if (ctrlWrite && wordPower == 2'h3) begin
                        state_reg <= acfg_pkg::ACFG_ST_SHUTDOWN;
                    end else if (ctrlWrite && wordPower == 2'h0) begin
                        state_reg <= acfg_pkg::ACFG_ST_READY;
                    end else if (ctrlWrite) begin
                        state_reg <= acfg_pkg::ACFG_ST_ASLEEP;
                    end else if (convStart) begin
                        state_reg <= acfg_pkg::ACFG_ST_CONVERT;
                    end
                end
                acfg_pkg::ACFG_ST_CONVERT: begin
                    if (ctrlWrite && wordPower == 2'h3) begin
                        state_reg <= acfg_pkg::ACFG_ST_SHUTDOWN;
                    end else if (ctrlWrite) begin
                        if (wordPower == 2'h0) begin
                            state_reg <= acfg_pkg::ACFG_ST_READY;
                        end else begin
                            state_reg <= acfg_pkg::ACFG_ST_ASLEEP;
                        end
                    end else if (frameDone || csRise) begin
                        if (autoPower) begin
                            state_reg <= acfg_pkg::ACFG_ST_ASLEEP;
                        end else begin
                            state_reg <= acfg_pkg::ACFG_ST_READY;
                        end
                    end
                end
                acfg_pkg::ACFG_ST_SHUTDOWN: begin
                    if (ctrlWrite && wordPower == 2'h0) begin
                        state_reg <= acfg_pkg::ACFG_ST_READY;
                    end else if (ctrlWrite && wordPower != 2'h3) begin
                        state_reg <= acfg_pkg::ACFG_ST_ASLEEP;
                    end
                end
                default: begin
                    state_reg <= acfg_pkg::ACFG_ST_READY;
                end
            endcase
        end
    end

    // Registered status from state and power field
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            convActive <= 1'b0;
            poweredDown <= 1'b0;
            refPowered <= 1'b1;
            powerMode <= acfg_pkg::ACFG_PWR_NORMAL;
        end else begin
            convActive <= (state_reg == acfg_pkg::ACFG_ST_CONVERT);
            powerMode <= acfg_pkg::acfg_power_t'(ctrlPower);
            poweredDown <= (state_reg == acfg_pkg::ACFG_ST_ASLEEP)
                || (state_reg == acfg_pkg::ACFG_ST_SHUTDOWN);
            refPowered <= !((state_reg == acfg_pkg::ACFG_ST_SHUTDOWN)
                || (state_reg == acfg_pkg::ACFG_ST_ASLEEP && ctrlPower == 2'h2));
        end
    end

endmodule

// >>> common/acfg_defines.svh
// Constants for the serial configuration register bank
`ifndef ACFG_DEFINES_SVH
`define ACFG_DEFINES_SVH

// Frame geometry
`define ACFG_FRAME_BITS 16
`define ACFG_COUNT_BITS 5
`define ACFG_LAST_BIT 5'h0f

// Frame header positions
`define ACFG_WRITE_POS 15
`define ACFG_ZERO_POS 14
`define ACFG_RSEL_POS 13

// Control payload in frame bits 12..1
`define ACFG_CTRL_HI 12
`define ACFG_CTRL_LO 1
`define ACFG_CTRL_RESET 12'h000

// Control fields, frame bit positions
`define ACFG_CHAN_POS 10
`define ACFG_CFG_HI 9
`define ACFG_CFG_LO 8
`define ACFG_PWR_HI 7
`define ACFG_PWR_LO 6
`define ACFG_CODING_POS 5
`define ACFG_REF_POS 4
`define ACFG_SEQ_HI 3
`define ACFG_SEQ_LO 2

// Range payload in frame bits 12..7
`define ACFG_RANGE_HI 12
`define ACFG_RANGE_LO 7
`define ACFG_RANGE_RESET 6'h00
`define ACFG_RANGE0_HI 5
`define ACFG_RANGE0_LO 4
`define ACFG_RANGE1_HI 1
`define ACFG_RANGE1_LO 0

`endif

// >>> common/acfg_pkg.sv
// Types for the serial configuration register bank
package acfg_pkg;

    typedef enum logic [1:0] {
        ACFG_CFG_SINGLE = 2'h0,
        ACFG_CFG_PSEUDO = 2'h1,
        ACFG_CFG_DIFF = 2'h2,
        ACFG_CFG_BAD = 2'h3
    } acfg_input_cfg_t;

    typedef enum logic [1:0] {
        ACFG_PWR_NORMAL = 2'h0,
        ACFG_PWR_AUTOSTBY = 2'h1,
        ACFG_PWR_AUTOSHDN = 2'h2,
        ACFG_PWR_FULLSHDN = 2'h3
    } acfg_power_t;

    typedef enum {
        ACFG_ST_READY,
        ACFG_ST_CONVERT,
        ACFG_ST_ASLEEP,
        ACFG_ST_SHUTDOWN
    } acfg_state_t;

endpackage

// >>> common/acfg_frame_if.sv
// Received frame word and its completion toggle, link side to core side
`timescale 1ns/10ps
interface acfg_frame_if;
    logic [15:0] frameWord;
    logic frameToggle;

    modport tx (
        output frameWord,
        output frameToggle
    );

    modport rx (
        input frameWord,
        input frameToggle
    );
endinterface

// >>> src/acfg_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/10ps
`include "acfg_defines.svh"
module acfg_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;

    ////////////////////////////////////////////////////////////////////////
    // First stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= INIT;
            syncOut <= INIT;
        end else begin
            stage1_reg <= asyncIn;
            syncOut <= stage1_reg;
        end
    end

endmodule

// >>> src/acfg_frame_rx.sv
// Link-side frame shifter on the serial clock
`timescale 1ns/10ps
`include "acfg_defines.svh"
module acfg_frame_rx (
    // Link clock and reset
    input wire logic serialClk,
    input wire logic rst,
    // Link pins
    input wire logic chipSelN,
    input wire logic serialDataIn,
    // Completed frame
    acfg_frame_if.tx frame
);

    logic [`ACFG_COUNT_BITS-1:0] bitCount_reg;
    logic [`ACFG_FRAME_BITS-2:0] shift_reg;
    logic lastEdge;

    assign lastEdge = (bitCount_reg == `ACFG_LAST_BIT);

    ////////////////////////////////////////////////////////////////////////
    // Bit counter, cleared by the frame's own select
    always_ff @(posedge serialClk or posedge rst or posedge chipSelN) begin
        if (rst || chipSelN) begin
            bitCount_reg <= '0;
        end else if (bitCount_reg <= `ACFG_LAST_BIT) begin
            bitCount_reg <= bitCount_reg + 5'h01;
        end
    end

    // Shift in most significant bit first
    always_ff @(posedge serialClk or posedge rst or posedge chipSelN) begin
        if (rst || chipSelN) begin
            shift_reg <= '0;
        end else if (bitCount_reg <= `ACFG_LAST_BIT) begin
            shift_reg <= {shift_reg[`ACFG_FRAME_BITS-3:0], serialDataIn};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Word and toggle only on the sixteenth edge
    always_ff @(posedge serialClk or posedge rst) begin
        if (rst) begin
            frame.frameWord <= 16'h0000;
            frame.frameToggle <= 1'b0;
        end else if (!chipSelN && lastEdge) begin
            frame.frameWord <= {shift_reg, serialDataIn};
            frame.frameToggle <= ~frame.frameToggle;
        end
    end

endmodule

// >>> verification/acfg_config_bank_sva.sv
// Concurrent checks on the configuration bank ports
`timescale 1ns/10ps
module acfg_config_bank_sva (
    // Core clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Serial link
    input wire logic serialClk,
    input wire logic chipSelN,
    input wire logic serialDataIn,
    // Conversion setup
    input wire logic convActive,
    input wire logic activeChannel,
    input wire logic posInputSel,
    input wire logic negToGround,
    input wire acfg_pkg::acfg_input_cfg_t inputConfig,
    input wire logic configInvalid,
    input wire logic [1:0] activeRange,
    input wire logic codingStraight,
    input wire logic refInternal,
    input wire logic seqRunning,
    // Power state
    input wire acfg_pkg::acfg_power_t powerMode,
    input wire logic poweredDown,
    input wire logic refPowered
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    a_single_route: assert property (
        inputConfig == acfg_pkg::ACFG_CFG_SINGLE |-> negToGround && posInputSel == activeChannel)
        else $error("single-ended routing wrong");
    a_pair_route: assert property (
        inputConfig inside {acfg_pkg::ACFG_CFG_PSEUDO, acfg_pkg::ACFG_CFG_DIFF}
        |-> !negToGround && !posInputSel)
        else $error("pair routing wrong");
    a_bad_config: assert property (
        configInvalid == (inputConfig == acfg_pkg::ACFG_CFG_BAD))
        else $error("invalid config flag wrong");
    a_setup_held: assert property (
        convActive && $past(convActive)
        |-> $stable({activeChannel, activeRange, codingStraight, refInternal, seqRunning}))
        else $error("setup changed in mid conversion");
    a_conv_start: assert property (
        $fell(chipSelN) && powerMode != acfg_pkg::ACFG_PWR_FULLSHDN |-> ##[1:6] convActive)
        else $error("conversion did not start");
    a_power_commit: assert property (
        $changed(powerMode) |-> $past(convActive) || $past(convActive, 2)
        || $past(powerMode) == acfg_pkg::ACFG_PWR_FULLSHDN)
        else $error("power mode changed outside a frame");
    a_full_shutdown: assert property (
        powerMode == acfg_pkg::ACFG_PWR_FULLSHDN |-> ##[0:2] (poweredDown && !refPowered))
        else $error("full shutdown flags wrong");
    a_normal_awake: assert property (
        (powerMode == acfg_pkg::ACFG_PWR_NORMAL && !convActive)[*3] |-> !poweredDown && refPowered)
        else $error("normal mode not awake");
    a_standby_ref: assert property (
        powerMode == acfg_pkg::ACFG_PWR_AUTOSTBY && $stable(powerMode) |-> refPowered)
        else $error("standby lost reference");
endmodule

bind acfg_config_bank acfg_config_bank_sva acfg_config_bank_sva_inst (
    .ref_clk(ref_clk), .rst(rst), .serialClk(serialClk), .chipSelN(chipSelN),
    .serialDataIn(serialDataIn), .convActive(convActive), .activeChannel(activeChannel),
    .posInputSel(posInputSel), .negToGround(negToGround), .inputConfig(inputConfig),
    .configInvalid(configInvalid), .activeRange(activeRange),
    .codingStraight(codingStraight), .refInternal(refInternal), .seqRunning(seqRunning),
    .powerMode(powerMode), .poweredDown(poweredDown), .refPowered(refPowered)
);

// >>> verification/acfg_host_model.sv
// Host serial port model sending configuration frames
`timescale 1ns/10ps
module acfg_host_model (
    // Link pins
    output logic serialClk,
    output logic chipSelN,
    output logic serialDataIn
);
    initial begin
        serialClk = 1'b0;
        chipSelN = 1'b1;
        serialDataIn = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Top n bits of a frame, MSB first, clock idle outside frames
    task automatic send(input logic [15:0] w, input int n);
        int i;
        #7;
        chipSelN = 1'b0;
        for (i = 15; i > 15 - n; i--) begin
            serialDataIn = w[i];
            #40;
            serialClk = 1'b1;
            #40;
            serialClk = 1'b0;
        end
        #40;
        chipSelN = 1'b1;
        serialDataIn = ~serialDataIn;
    endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench for the serial configuration register bank
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    // Clock, reset and link
    logic ref_clk, rst;
    wire serialClk, chipSelN, serialDataIn;
    // Design outputs
    logic convActive, activeChannel, posInputSel, negToGround, configInvalid;
    logic codingStraight, refInternal, seqRunning, poweredDown, refPowered;
    logic [1:0] activeRange;
    acfg_pkg::acfg_input_cfg_t inputConfig;
    acfg_pkg::acfg_power_t powerMode;
    // Expectation model
    logic [11:0] ctrlExp;
    logic [5:0] rangeExp;
    logic seqPtr;
    int fails, num_checks;

    acfg_config_bank acfg_config_bank_inst (
        .ref_clk(ref_clk), .rst(rst), .serialClk(serialClk), .chipSelN(chipSelN),
        .serialDataIn(serialDataIn), .convActive(convActive), .activeChannel(activeChannel),
        .posInputSel(posInputSel), .negToGround(negToGround), .inputConfig(inputConfig),
        .configInvalid(configInvalid), .activeRange(activeRange),
        .codingStraight(codingStraight), .refInternal(refInternal), .seqRunning(seqRunning),
        .powerMode(powerMode), .poweredDown(poweredDown), .refPowered(refPowered)
    );
    acfg_host_model acfg_host_model_inst (
        .serialClk(serialClk), .chipSelN(chipSelN), .serialDataIn(serialDataIn)
    );
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        #3000000;
        fails++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Setup latched for the conversion of the frame just sent
    task automatic check_setup(input logic seqOn);
        logic ch;
        logic [1:0] cfg;
        ch = seqOn ? seqPtr : ctrlExp[9];
        cfg = ctrlExp[8:7];
        `CHK(activeChannel, ch)
        `CHK(inputConfig, cfg)
        `CHK(configInvalid, cfg == 2'h3)
        if (cfg != 2'h3) begin
            `CHK(posInputSel, (cfg == 2'h0) ? ch : 1'b0)
            `CHK(negToGround, cfg == 2'h0)
        end
        `CHK(activeRange, ch ? rangeExp[1:0] : rangeExp[5:4])
        `CHK(codingStraight, ctrlExp[4])
        `CHK(refInternal, ctrlExp[3])
        `CHK(seqRunning, seqOn)
    endtask
    // One frame, then power checks, plus setup checks after a full sixteen-bit frame
    task automatic frame(input logic [15:0] w, input int n);
        logic seqOn;
        int k;
        seqOn = ctrlExp[2:1] == 2'b10;
        @(negedge ref_clk);
        acfg_host_model_inst.send(w, n);
        if (n == 16) begin
            k = 0;
            while (convActive !== 1'b0 && k < 30) begin
                @(negedge ref_clk);
                k++;
            end
            if (k == 30) begin
                fails++;
                print_verdict();
            end
            repeat (4) @(negedge ref_clk);
            check_setup(seqOn);
            if (seqOn) seqPtr = (seqPtr == ctrlExp[9]) ? 1'b0 : ~seqPtr;
            if (w[15:14] == 2'b10 && w[13]) rangeExp = w[12:7];
            if (w[15:13] == 3'b100) begin
                ctrlExp = w[12:1];
                if (w[3:2] == 2'b10) seqPtr = 1'b0;
            end
            `CHK(powerMode, ctrlExp[6:5])
            `CHK(poweredDown, ctrlExp[6:5] != 2'h0)
            `CHK(refPowered, ~ctrlExp[6])
        end else begin
            repeat (6) @(negedge ref_clk);
            `CHK(convActive, 1'b0)
            `CHK(powerMode, ctrlExp[6:5])
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic [15:0] w;
        fails = 0;
        num_checks = 0;
        ctrlExp = 12'h000;
        rangeExp = 6'h00;
        seqPtr = 1'b0;
        rst = 1'b1;
        r = $urandom(62);
        repeat (5) @(negedge ref_clk);
        `CHK({convActive, negToGround, refPowered, poweredDown, powerMode}, 6'h18)
        rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        frame(16'h0000, 16);
        frame(16'h8030, 10);
        frame(16'h80c0, 15);
        frame(16'hc030, 16);
        frame(16'h0030, 16);
        frame(16'hb180, 16);
        frame(16'h8438, 16);
        repeat (3) frame(16'h0000, 16);
        frame(16'h8000, 16);
        for (int i = 0; i < 24; i++) begin
            r = $urandom;
            if (r[11]) w = {r[0] | r[1], 2'b01, r[7:2], 7'h00};
            else w = {r[0] | r[1], 4'h0, r[8:2], {2{r[9]}}, 1'b0, r[10]};
            frame(w, 16);
        end
        print_verdict();
    end
endmodule
